// ### fieldbus_ctrl.sv
// combined read/write transaction engine with command word decoding
// Function
// R1: writes of a combined transaction finish before any of its reads.
// R2: register addresses on the link count from zero.
// R3: master sends address, function, read span, write span, count, data, check.
// R4: reply holds address, function, read byte count, read data.
// R5: each reply register goes high byte first, then low byte.
// R6: bits 1:0 pick one of four preset references.
// R7: bit 2 clear brakes with DC; set allows normal ramping.
// R8: bit 3 clear switches the output stage off so the motor coasts.
// R9: bit 4 clear stops with the quick-stop ramp.
// R10: bit 5 clear freezes the output frequency.
// R11: while frozen only coast, DC brake or input stops act; here a ramp stop from the start input is held off too.
// R12: bit 6 clear ramps to stop; set permits start.
// R13: trip reset only on a rising bit 7.
// R14: bit 8 set runs at jog speed.
// R15: bit 9 picks ramp pair 1 or 2.
// R16: bit 10 clear makes the whole command word ignored.
// R17: bit 11 drives relay 1 only when its function is option 36.
// R18: bit 12 drives relay 2 only when its function is option 37.
// R19: bit 13 picks set-up 1 or 2 under multi set-up option 9.
// R20: bit 15 reverses only when reversing source allows the bus.
// R21: coast, start, reference and set-up bits gate with digital inputs.
// R22: bit 14 does nothing.
// R23: a query with a failed check gets no reply.
`default_nettype none

module fieldbus_ctrl
    import fieldbus_pkg::*;
#(
    parameter int RD_MAX = MAX_RD_WORDS,
    parameter int WR_MAX = MAX_WR_WORDS
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] my_addr,
    input wire logic [7:0] rx_byte,
    input wire logic rx_valid,
    input wire logic rx_end,
    input wire logic rx_crc_ok,
    output logic [7:0] tx_byte,
    output logic tx_valid,
    output logic tx_last,
    input wire logic tx_ready,
    output logic reg_wr_en,
    output logic reg_rd_en,
    output logic [15:0] reg_addr,
    output logic [15:0] reg_wr_data,
    input wire logic [15:0] reg_rd_data,
    output logic busy,
    input wire logic di_ref0,
    input wire logic di_ref1,
    input wire logic di_coast,
    input wire logic di_start,
    input wire logic di_setup,
    input wire logic di_reverse,
    input wire logic di_dc_brake,
    input wire gate_t coast_gate,
    input wire gate_t start_gate,
    input wire gate_t ref_gate,
    input wire gate_t setup_gate,
    input wire gate_t reverse_gate,
    input wire logic [7:0] relay1_func,
    input wire logic [7:0] relay2_func,
    input wire logic [7:0] active_setup,
    input wire logic relay1_other,
    input wire logic relay2_other,
    output logic [15:0] cmd_word_q,
    output logic [1:0] preset_sel_q,
    output logic dc_brake_q,
    output logic coast_q,
    output logic quick_stop_q,
    output logic freq_hold_q,
    output logic ramp_stop_q,
    output logic trip_reset_q,
    output logic jog_q,
    output logic ramp2_q,
    output logic relay1_q,
    output logic relay2_q,
    output logic setup2_q,
    output logic reverse_q
);

    typedef enum logic [4:0]
    {
        S_RX = 5'b00001,
        S_WR = 5'b00010,
        S_TX = 5'b00100,
        S_RD = 5'b01000,
        S_RD_CAP = 5'b10000
    } state_t;

    typedef enum logic [2:0]
    {
        PH_ADDR = 3'h0,
        PH_FN = 3'h1,
        PH_BC = 3'h2,
        PH_HI = 3'h3,
        PH_LO = 3'h4
    } phase_t;

    // ----------------------------------------
    // query capture
    // ----------------------------------------
    logic [15:0] wbuf [WR_MAX];
    logic [7:0] cnt_q;
    logic [7:0] slave_q;
    logic [7:0] fn_q;
    logic [15:0] rs_q;
    logic [15:0] rq_q;
    logic [15:0] ws_q;
    logic [15:0] wq_q;
    logic [7:0] bc_q;
    logic ovf_q;
    state_t state_q;
    phase_t ph_q;
    logic [15:0] idx_q;
    logic [15:0] rdata_q;
    logic [7:0] tx_q;
    logic [7:0] data_pos;
    logic query_ok;

    assign data_pos = cnt_q - HDR_BYTES;

    // fields land in order as they arrive
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q <= 8'h00;
            slave_q <= 8'h00;
            fn_q <= 8'h00;
            rs_q <= 16'h0000;
            rq_q <= 16'h0000;
            ws_q <= 16'h0000;
            wq_q <= 16'h0000;
            bc_q <= 8'h00;
            ovf_q <= 1'b0;
        end
        else if (state_q == S_RX && rx_end)
        begin
            cnt_q <= 8'h00;
            ovf_q <= 1'b0;
        end
        else if (state_q == S_RX && rx_valid)
        begin
            if (cnt_q == 8'hff)
                ovf_q <= 1'b1;
            else
                cnt_q <= cnt_q + 8'h01;
            case (cnt_q) // [R3]
                8'h00: slave_q <= rx_byte;
                POS_FN: fn_q <= rx_byte;
                POS_RS_HI: rs_q[15:8] <= rx_byte;
                POS_RS_LO: rs_q[7:0] <= rx_byte;
                POS_RQ_HI: rq_q[15:8] <= rx_byte;
                POS_RQ_LO: rq_q[7:0] <= rx_byte;
                POS_WS_HI: ws_q[15:8] <= rx_byte;
                POS_WS_LO: ws_q[7:0] <= rx_byte;
                POS_WQ_HI: wq_q[15:8] <= rx_byte;
                POS_WQ_LO: wq_q[7:0] <= rx_byte;
                POS_BC: bc_q <= rx_byte;
                default: ;
            endcase
        end
    end

    // write data kept until the check is known good
    always_ff @(posedge sys_clk)
    begin
        if (state_q == S_RX && rx_valid && cnt_q >= HDR_BYTES
            && 32'(data_pos[7:1]) < WR_MAX)
        begin
            if (data_pos[0])
                wbuf[data_pos[7:1]][7:0] <= rx_byte;
            else
                wbuf[data_pos[7:1]][15:8] <= rx_byte;
        end
    end

    // broadcast is refused: the transaction always needs a reply
    assign query_ok = rx_crc_ok && !ovf_q // [R23]
                      && slave_q == my_addr && slave_q != ADDR_BROADCAST
                      && fn_q == FN_RW_MULTI
                      && rq_q != 16'h0000 && 32'(rq_q) <= RD_MAX
                      && wq_q != 16'h0000 && 32'(wq_q) <= WR_MAX
                      && {8'h00, bc_q} == {wq_q[14:0], 1'b0}
                      && cnt_q == HDR_BYTES + bc_q;

    // ----------------------------------------
    // transaction sequencer
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= S_RX;
            ph_q <= PH_ADDR;
            idx_q <= 16'h0000;
            rdata_q <= 16'h0000;
            tx_q <= 8'h00;
        end
        else
        begin
            case (state_q)
                S_RX:
                begin
                    idx_q <= 16'h0000;
                    if (rx_end && query_ok)
                        state_q <= S_WR;
                end
                S_WR:
                begin
                    idx_q <= idx_q + 16'h0001;
                    if (idx_q == wq_q - 16'h0001) // [R1]
                    begin
                        idx_q <= 16'h0000;
                        tx_q <= slave_q;
                        ph_q <= PH_ADDR;
                        state_q <= S_TX;
                    end
                end
                S_TX:
                begin
                    if (tx_ready)
                    begin
                        case (ph_q) // [R4]
                            PH_ADDR:
                            begin
                                tx_q <= fn_q;
                                ph_q <= PH_FN;
                            end
                            PH_FN:
                            begin
                                tx_q <= {rq_q[6:0], 1'b0};
                                ph_q <= PH_BC;
                            end
                            PH_BC:
                                state_q <= S_RD;
                            PH_HI:
                            begin
                                tx_q <= rdata_q[7:0]; // [R5]
                                ph_q <= PH_LO;
                            end
                            PH_LO:
                            begin
                                idx_q <= idx_q + 16'h0001;
                                if (idx_q == rq_q - 16'h0001)
                                    state_q <= S_RX;
                                else
                                    state_q <= S_RD;
                            end
                            default:
                                state_q <= S_RX;
                        endcase
                    end
                end
                S_RD:
                    state_q <= S_RD_CAP;
                S_RD_CAP:
                begin
                    rdata_q <= reg_rd_data;
                    tx_q <= reg_rd_data[15:8]; // [R5]
                    ph_q <= PH_HI;
                    state_q <= S_TX;
                end
                default:
                    state_q <= S_RX;
            endcase
        end
    end

    // ----------------------------------------
    // register port and reply stream
    // ----------------------------------------
    // link addresses are zero based, so they go out untouched
    assign reg_wr_en = (state_q == S_WR);
    assign reg_rd_en = (state_q == S_RD);
    assign reg_addr = (state_q == S_WR) ? ws_q + idx_q : rs_q + idx_q; // [R2]
    assign reg_wr_data = wbuf[idx_q[6:0]];
    assign tx_valid = (state_q == S_TX);
    assign tx_byte = tx_q;
    assign tx_last = (state_q == S_TX) && ph_q == PH_LO && idx_q == rq_q - 16'h0001;
    assign busy = (state_q != S_RX);

    logic cmd_load;
    assign cmd_load = reg_wr_en && reg_addr == CMD_REG_ADDR;

    cmd_decode u_decode
    (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .cmd_load(cmd_load),
        .cmd_word(reg_wr_data),
        .di_ref0(di_ref0),
        .di_ref1(di_ref1),
        .di_coast(di_coast),
        .di_start(di_start),
        .di_setup(di_setup),
        .di_reverse(di_reverse),
        .di_dc_brake(di_dc_brake),
        .coast_gate(coast_gate),
        .start_gate(start_gate),
        .ref_gate(ref_gate),
        .setup_gate(setup_gate),
        .reverse_gate(reverse_gate),
        .relay1_func(relay1_func),
        .relay2_func(relay2_func),
        .active_setup(active_setup),
        .relay1_other(relay1_other),
        .relay2_other(relay2_other),
        .cmd_q(cmd_word_q),
        .preset_sel_q(preset_sel_q),
        .dc_brake_q(dc_brake_q),
        .coast_q(coast_q),
        .quick_stop_q(quick_stop_q),
        .freq_hold_q(freq_hold_q),
        .ramp_stop_q(ramp_stop_q),
        .trip_reset_q(trip_reset_q),
        .jog_q(jog_q),
        .ramp2_q(ramp2_q),
        .relay1_q(relay1_q),
        .relay2_q(relay2_q),
        .setup2_q(setup2_q),
        .reverse_q(reverse_q)
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    logic writes_done_q;
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            writes_done_q <= 1'b0;
        else if (state_q == S_RX)
            writes_done_q <= 1'b0;
        else if (state_q == S_WR && idx_q == wq_q - 16'h0001)
            writes_done_q <= 1'b1;
    end

    property p_write_first;
        reg_rd_en |-> writes_done_q && !reg_wr_en;
    endproperty
    a_write_first: assert property (p_write_first) // [R1]
        else $error("read issued before all writes");

    property p_bad_crc_silent;
        state_q == S_RX && rx_end && !rx_crc_ok |=> state_q == S_RX && !tx_valid;
    endproperty
    a_bad_crc_silent: assert property (p_bad_crc_silent) // [R23]
        else $error("reply started for failed check");

    property p_byte_count;
        tx_valid && tx_ready && ph_q == PH_FN |=> tx_byte == {rq_q[6:0], 1'b0};
    endproperty
    a_byte_count: assert property (p_byte_count) // [R4]
        else $error("byte count does not match read size");

    property p_hi_then_lo;
        tx_valid && tx_ready && ph_q == PH_HI |=> tx_valid && ph_q == PH_LO
            && tx_byte == rdata_q[7:0];
    endproperty
    a_hi_then_lo: assert property (p_hi_then_lo) // [R5]
        else $error("low byte not after high byte");

    property p_hold_byte;
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte);
    endproperty
    a_hold_byte: assert property (p_hold_byte) // [R4]
        else $error("reply byte changed while stalled");

    property p_zero_based;
        reg_wr_en && idx_q == 16'h0000 |-> reg_addr == ws_q;
    endproperty
    a_zero_based: assert property (p_zero_based) // [R2]
        else $error("write address offset from link address");

    property p_cmd_reach;
        cmd_load && reg_wr_data[B_VALID] |=> cmd_word_q == $past(reg_wr_data);
    endproperty
    a_cmd_reach: assert property (p_cmd_reach) // [R16]
        else $error("valid command word not taken");

    c_full_txn: cover property (tx_last && tx_ready);
    c_cmd_write: cover property (cmd_load && reg_wr_data[B_VALID]);
    c_stall: cover property (tx_valid && !tx_ready ##1 tx_valid && tx_ready);

endmodule // fieldbus_ctrl

`default_nettype wire

// ### fieldbus_pkg.sv
// constants and helpers shared by the fieldbus command block
`default_nettype none

package fieldbus_pkg;

    // ----------------------------------------
    // transaction framing
    // ----------------------------------------
    localparam logic [7:0] FN_RW_MULTI = 8'h17;
    localparam logic [7:0] ADDR_BROADCAST = 8'h00;
    localparam logic [7:0] HDR_BYTES = 8'h0b;
    localparam logic [7:0] POS_FN = 8'h01;
    localparam logic [7:0] POS_RS_HI = 8'h02;
    localparam logic [7:0] POS_RS_LO = 8'h03;
    localparam logic [7:0] POS_RQ_HI = 8'h04;
    localparam logic [7:0] POS_RQ_LO = 8'h05;
    localparam logic [7:0] POS_WS_HI = 8'h06;
    localparam logic [7:0] POS_WS_LO = 8'h07;
    localparam logic [7:0] POS_WQ_HI = 8'h08;
    localparam logic [7:0] POS_WQ_LO = 8'h09;
    localparam logic [7:0] POS_BC = 8'h0a;
    localparam int MAX_RD_WORDS = 125;
    localparam int MAX_WR_WORDS = 121;

    // ----------------------------------------
    // command word
    // ----------------------------------------
    localparam logic [15:0] CMD_REG_ADDR = 16'h0000;
    localparam logic [15:0] CMD_RESET = 16'h0000;
    localparam int B_REF0 = 0;
    localparam int B_REF1 = 1;
    localparam int B_RAMP_NOT_DCB = 2;
    localparam int B_NO_COAST = 3;
    localparam int B_NO_QSTOP = 4;
    localparam int B_USE_RAMP = 5;
    localparam int B_START = 6;
    localparam int B_RESET = 7;
    localparam int B_JOG = 8;
    localparam int B_RAMP2 = 9;
    localparam int B_VALID = 10;
    localparam int B_RELAY1 = 11;
    localparam int B_RELAY2 = 12;
    localparam int B_SETUP = 13;
    localparam int B_REVERSE = 15;
    localparam logic [7:0] RELAY1_BUS_OPT = 8'h24;
    localparam logic [7:0] RELAY2_BUS_OPT = 8'h25;
    localparam logic [7:0] SETUP_MULTI_OPT = 8'h09;

    typedef enum logic [1:0]
    {
        GATE_DI = 2'h0,
        GATE_BUS = 2'h1,
        GATE_OR = 2'h2,
        GATE_AND = 2'h3
    } gate_t;

    function automatic logic gate_fn(input gate_t sel, input logic bus, input logic di);
        case (sel)
            GATE_DI: gate_fn = di;
            GATE_BUS: gate_fn = bus;
            GATE_OR: gate_fn = bus | di;
            GATE_AND: gate_fn = bus & di;
            default: gate_fn = di;
        endcase
    endfunction

endpackage

`default_nettype wire

// ### cmd_decode.sv
// command word latch and drive-function decoder
`default_nettype none

module cmd_decode
    import fieldbus_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic cmd_load,
    input wire logic [15:0] cmd_word,
    input wire logic di_ref0,
    input wire logic di_ref1,
    input wire logic di_coast,
    input wire logic di_start,
    input wire logic di_setup,
    input wire logic di_reverse,
    input wire logic di_dc_brake,
    input wire gate_t coast_gate,
    input wire gate_t start_gate,
    input wire gate_t ref_gate,
    input wire gate_t setup_gate,
    input wire gate_t reverse_gate,
    input wire logic [7:0] relay1_func,
    input wire logic [7:0] relay2_func,
    input wire logic [7:0] active_setup,
    input wire logic relay1_other,
    input wire logic relay2_other,
    output logic [15:0] cmd_q,
    output logic [1:0] preset_sel_q,
    output logic dc_brake_q,
    output logic coast_q,
    output logic quick_stop_q,
    output logic freq_hold_q,
    output logic ramp_stop_q,
    output logic trip_reset_q,
    output logic jog_q,
    output logic ramp2_q,
    output logic relay1_q,
    output logic relay2_q,
    output logic setup2_q,
    output logic reverse_q
);

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [6:0] di_meta_q;
    logic [6:0] di_q;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            di_meta_q <= 7'h00;
            di_q <= 7'h00;
        end
        else
        begin
            di_meta_q <= {di_dc_brake, di_reverse, di_setup, di_start, di_coast, di_ref1, di_ref0};
            di_q <= di_meta_q;
        end
    end

    // ----------------------------------------
    // command latch
    // ----------------------------------------
    logic load_ok;
    assign load_ok = cmd_load & cmd_word[B_VALID]; // [R16]

    // bit 14 is stored but drives nothing [R22]
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            cmd_q <= CMD_RESET;
        else if (load_ok)
            cmd_q <= cmd_word; // [R16]
    end

    // only a fresh rising bit resets; a held level does nothing
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            trip_reset_q <= 1'b0;
        else
            trip_reset_q <= load_ok & cmd_word[B_RESET] & ~cmd_q[B_RESET]; // [R13]
    end

    // ----------------------------------------
    // function outputs
    // ----------------------------------------
    logic hold;
    assign hold = ~cmd_q[B_USE_RAMP];

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            preset_sel_q <= 2'h0;
            dc_brake_q <= 1'b0;
            coast_q <= 1'b1;
            quick_stop_q <= 1'b0;
            freq_hold_q <= 1'b0;
            ramp_stop_q <= 1'b0;
            jog_q <= 1'b0;
            ramp2_q <= 1'b0;
            setup2_q <= 1'b0;
            reverse_q <= 1'b0;
        end
        else
        begin
            preset_sel_q <= {gate_fn(ref_gate, cmd_q[B_REF1], di_q[1]),
                             gate_fn(ref_gate, cmd_q[B_REF0], di_q[0])}; // [R6] [R21]
            dc_brake_q <= ~cmd_q[B_RAMP_NOT_DCB] | di_q[6]; // [R7] [R11]
            coast_q <= gate_fn(coast_gate, ~cmd_q[B_NO_COAST], di_q[2]); // [R8] [R21]
            // ramp stops are held off while the frequency is frozen
            quick_stop_q <= ~cmd_q[B_NO_QSTOP] & ~hold; // [R9] [R11]
            freq_hold_q <= hold; // [R10]
            ramp_stop_q <= ~gate_fn(start_gate, cmd_q[B_START], di_q[3]) & ~hold; // [R12] [R21]
            jog_q <= cmd_q[B_JOG]; // [R14]
            ramp2_q <= cmd_q[B_RAMP2]; // [R15]
            setup2_q <= (active_setup == SETUP_MULTI_OPT)
                        & gate_fn(setup_gate, cmd_q[B_SETUP], di_q[4]); // [R19] [R21]
            reverse_q <= gate_fn(reverse_gate, cmd_q[B_REVERSE], di_q[5]); // [R20]
        end
    end

    // relays follow the bus only when set up for it
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            relay1_q <= 1'b0;
            relay2_q <= 1'b0;
        end
        else
        begin
            relay1_q <= (relay1_func == RELAY1_BUS_OPT) ? cmd_q[B_RELAY1] : relay1_other; // [R17]
            relay2_q <= (relay2_func == RELAY2_BUS_OPT) ? cmd_q[B_RELAY2] : relay2_other; // [R18]
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    property p_invalid_ignored;
        cmd_load && !cmd_word[B_VALID] |=> $stable(cmd_q);
    endproperty
    a_invalid_ignored: assert property (p_invalid_ignored) // [R16]
        else $error("command word taken with valid bit clear");

    property p_reset_edge;
        trip_reset_q |-> $past(load_ok) && !$past(cmd_q[B_RESET]) && cmd_q[B_RESET];
    endproperty
    a_reset_edge: assert property (p_reset_edge) // [R13]
        else $error("trip reset without rising bit");

    property p_relay1;
        relay1_func == RELAY1_BUS_OPT && $stable(relay1_func) |=> relay1_q == $past(cmd_q[B_RELAY1]);
    endproperty
    a_relay1: assert property (p_relay1) // [R17]
        else $error("relay 1 not following bus bit");

    property p_hold_no_qstop;
        !cmd_q[B_USE_RAMP] |=> !quick_stop_q && !ramp_stop_q;
    endproperty
    a_hold_no_qstop: assert property (p_hold_no_qstop) // [R11]
        else $error("ramp stop acted while frozen");

    c_trip_reset: cover property (trip_reset_q);
    c_relay2: cover property (relay2_func == RELAY2_BUS_OPT && relay2_q);

endmodule // cmd_decode

`default_nettype wire

// ### reg_store_model.sv
// parameter-store model sitting on the register port of the block
`default_nettype none
module reg_store_model
(
    input wire logic sys_clk,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wr_data,
    output logic [15:0] reg_rd_data
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // store and read port
    // ----------------------------------------
    logic [15:0] mem [16];
    always @(posedge sys_clk)
    begin
        if (reg_wr_en)
            mem[reg_addr[3:0]] <= reg_wr_data;
        // idle data inverted, so a late sample never matches by luck
        reg_rd_data <= reg_rd_en ? mem[reg_addr[3:0]] : ~reg_rd_data;
    end
endmodule // reg_store_model
`default_nettype wire

// ### testbench.sv
// self-checking bench for the fieldbus command block
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin n_mismatch++; \
    $display("Error %s exp %h got %h", n, e, s); end end
module testbench
    import fieldbus_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // stimulus, reply checks, verdict
    // ----------------------------------------
    logic sys_clk = 1'h0, rst_n = 1'h0, rx_valid = 1'h0, rx_end = 1'h0, rx_crc_ok = 1'h0;
    logic tx_ready = 1'h0, relay1_other = 1'h0, relay2_other = 1'h1, di_ref0 = 1'h0;
    logic di_ref1 = 1'h0, di_coast = 1'h0, di_start = 1'h0, di_setup = 1'h0;
    logic di_reverse = 1'h0, di_dc_brake = 1'h0;
    logic [7:0] my_addr = 8'h05, rx_byte = 8'h00, tx_byte;
    logic [7:0] relay1_func = 8'h00, relay2_func = 8'h00, active_setup = 8'h00;
    gate_t coast_gate = GATE_BUS, start_gate = GATE_BUS, ref_gate = GATE_BUS;
    gate_t setup_gate = GATE_BUS, reverse_gate = GATE_BUS;
    logic tx_valid, tx_last, reg_wr_en, reg_rd_en, busy, dc_brake_q, coast_q, quick_stop_q;
    logic freq_hold_q, ramp_stop_q, trip_reset_q, jog_q, ramp2_q, relay1_q, relay2_q;
    logic setup2_q, reverse_q;
    logic [1:0] preset_sel_q;
    logic [12:0] dexp;
    logic [15:0] reg_addr, reg_wr_data, reg_rd_data, cmd_word_q, cmd_next, cmd_exp = 16'h0000;
    logic [15:0] shadow [16];
    logic [7:0] ex [$];
    int n_mismatch = 0, checks_done = 0, n_trip = 0, exp_trip = 0, k;
    fieldbus_ctrl fieldbus_ctrl_inst (.*);
    reg_store_model reg_store_model_inst (.*);
    always #20 sys_clk = ~sys_clk;
    always @(negedge sys_clk)
        if (trip_reset_q === 1'h1)
            n_trip++;
    function automatic logic gated(input gate_t s, input logic b, input logic d);
        gated = (s == GATE_DI) ? d : (s == GATE_BUS) ? b : (s == GATE_OR) ? b | d : b & d;
    endfunction
    function automatic logic [12:0] dec(input logic [15:0] w);
        // ramp stops are held off while the output frequency is frozen
        dec = {gated(ref_gate, w[1], di_ref1), gated(ref_gate, w[0], di_ref0),
            ~w[2] | di_dc_brake, gated(coast_gate, ~w[3], di_coast), ~w[4] & w[5], ~w[5],
            ~gated(start_gate, w[6], di_start) & w[5], w[8], w[9],
            (relay1_func == RELAY1_BUS_OPT) ? w[11] : relay1_other,
            (relay2_func == RELAY2_BUS_OPT) ? w[12] : relay2_other,
            (active_setup == SETUP_MULTI_OPT) & w[13], gated(reverse_gate, w[15], di_reverse)};
    endfunction
    task automatic query(input logic [15:0] rs, rq, ws, wq, input logic ok);
        logic [7:0] q [$];
        logic [15:0] w;
        q = {my_addr, FN_RW_MULTI, rs[15:8], rs[7:0], rq[15:8], rq[7:0], ws[15:8], ws[7:0],
            wq[15:8], wq[7:0], 8'(2 * wq)};
        for (int i = 0; i < wq; i++)
        begin
            w = (ws == 0) ? cmd_next : 16'($urandom);
            q.push_back(w[15:8]);
            q.push_back(w[7:0]);
            if (ok)
                shadow[ws + i] = w;
        end
        @(posedge sys_clk);
        foreach (q[i])
        begin
            rx_byte <= q[i];
            rx_valid <= 1'h1;
            @(posedge sys_clk);
        end
        rx_valid <= 1'h0;
        rx_end <= 1'h1;
        rx_crc_ok <= ok;
        @(posedge sys_clk);
        rx_end <= 1'h0;
        ex = {};
        if (ok)
            ex = {my_addr, FN_RW_MULTI, 8'(2 * rq)};
        for (int i = 0; ok && i < rq; i++)
        begin
            ex.push_back(shadow[rs + i][15:8]);
            ex.push_back(shadow[rs + i][7:0]);
        end
        k = 0;
        // sink stalls at random; checked mid-cycle where outputs have settled
        repeat (300)
        begin
            @(posedge sys_clk);
            tx_ready <= 1'($urandom);
            @(negedge sys_clk);
            if (tx_valid === 1'h1 && tx_ready === 1'h1 && k < ex.size())
            begin
                `CHK("reply byte", ex[k], tx_byte)
                `CHK("last flag", 1'(k == ex.size() - 1), tx_last)
                k++;
            end
        end
        `CHK("reply length", ex.size(), k)
        `CHK("busy", 1'h0, busy)
        $display("test done: %0d reply bytes", k);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        #(40 * 40000);
        n_mismatch++;
        wrap_up();
    end
    initial
    begin
        void'($urandom(32'hfc56));
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'h1;
        repeat (3) @(posedge sys_clk);
        query(16'h0001, 16'h0004, 16'h0001, 16'h0004, 1'h1);
        query(16'h0001, 16'h0004, 16'h0001, 16'h0004, 1'h0);
        query(16'h0002, 16'h0002, 16'h0005, 16'h0001, 1'h1);
        for (int t = 0; t < 10; t++)
        begin
            cmd_next = 16'($urandom);
            if (t < 2)
                cmd_next[10] = t[0];
            cmd_next[7] = cmd_next[7] | (t == 1);
            relay1_func <= 1'($urandom) ? RELAY1_BUS_OPT : 8'h00;
            relay2_func <= 1'($urandom) ? RELAY2_BUS_OPT : 8'h00;
            active_setup <= 1'($urandom) ? SETUP_MULTI_OPT : 8'h01;
            relay1_other <= 1'($urandom);
            {di_ref0, di_ref1, di_coast, di_start} <= 4'($urandom);
            {di_setup, di_reverse, di_dc_brake} <= 3'($urandom);
            coast_gate <= gate_t'(2'($urandom));
            start_gate <= gate_t'(2'($urandom));
            ref_gate <= gate_t'(2'($urandom));
            reverse_gate <= gate_t'(2'($urandom));
            @(posedge sys_clk);
            if (cmd_next[10])
            begin
                exp_trip += int'(cmd_next[7] & ~cmd_exp[7]);
                cmd_exp = cmd_next;
            end
            query(16'h0000, 16'h0001, 16'h0000, 16'h0001, 1'h1);
            `CHK("command word", cmd_exp, cmd_word_q)
            dexp = dec(cmd_exp);
            `CHK("stops", dexp[12:6], {preset_sel_q, dc_brake_q, coast_q, quick_stop_q,
                freq_hold_q, ramp_stop_q})
            `CHK("modes", dexp[5:0], {jog_q, ramp2_q, relay1_q, relay2_q, setup2_q,
                reverse_q})
            `CHK("trip resets", exp_trip, n_trip)
        end
        wrap_up();
    end
endmodule // testbench
`default_nettype wire
